// ### ldo_irq_mask_and_load_meter.sv
// Linear regulator interrupt masks and buck load current meter registers
//
// How it works
// - Bit 7 masks regulator one power-good loss
// - Bit 6 masks regulator one power-good gain
// - Bit 4 masks regulator one current limit
// - Bit 3 masks regulator zero power-good loss
// - Bit 2 masks regulator zero power-good gain
// - Bit 0 masks regulator zero current limit
// - Live status follows conditions regardless of masks
// - Select bit 0 picks converter zero or one
// - Every select write starts a new measurement
// - Nine-bit result split high bit 0, low byte
// - Result scaled 20 mA per LSB, 10.22 A
// - Reserved mask and high-result bits read zero
// - Completion raises ready interrupt unless masked
`timescale 1ns/100ps
`default_nettype none
`include "regulator_irq_mask_meter_defines.svh"

module ldo_irq_mask_and_load_meter (
	input  wire logic                              clk_sys,
	input  wire logic                              rst,
	input  wire regulator_irq_mask_meter_pkg::reg_req_type   reg_req,
	output var  logic [7:0]                        reg_rdata_ff,
	output var  logic                              reg_rvalid_ff,
	input  wire regulator_irq_mask_meter_pkg::ldo_flags_type ldo_cond,
	output var  regulator_irq_mask_meter_pkg::ldo_flags_type status_ff,
	output var  regulator_irq_mask_meter_pkg::ldo_flags_type irq_set_ff,
	output var  logic                              meas_start_ff,
	output var  logic                              meas_sel_ff,
	input  wire logic                              meas_done,
	input  wire logic [8:0]                        meas_result,
	input  wire logic                              measure_ready_mask,
	output var  logic                              measure_ready_irq_ff
);
	import regulator_irq_mask_meter_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0]    mask_ff;
	logic [7:0]    select_ff;
	logic [8:0]    result_ff;
	ldo_flags_type cond_meta_ff;
	ldo_flags_type cond_sync_ff;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	wire logic hit_mask;
	wire logic hit_select;
	wire logic hit_high;
	wire logic hit_low;
	wire logic wr_mask;
	wire logic wr_select;

	assign hit_mask   = (reg_req.addr == `OFS_REGULATOR_IRQ_MASK);
	assign hit_select = (reg_req.addr == `OFS_LOAD_MEASURE_SELECT);
	assign hit_high   = (reg_req.addr == `OFS_LOAD_CURRENT_HIGH);
	assign hit_low    = (reg_req.addr == `OFS_LOAD_CURRENT_LOW);
	assign wr_mask    = reg_req.wr & hit_mask;
	assign wr_select  = reg_req.wr & hit_select;

	// Result registers are read only; writes to them fall away
	wire logic [7:0] rd_mux;
	assign rd_mux = hit_mask   ? (mask_ff & `MASK_WRITABLE_BITS) :
	                hit_select ? select_ff :
	                hit_high   ? {7'h00, result_ff[8]} :
	                hit_low    ? result_ff[7:0] :
	                8'h00;

	// ----------------------------------------
	// Edge detection on synchronised conditions
	// ----------------------------------------
	wire logic [1:0] pg_lost;
	wire logic [1:0] pg_gained;
	wire logic [1:0] cl_hit;
	wire logic [1:0] lost_mask;
	wire logic [1:0] gained_mask;
	wire logic [1:0] cl_mask;
	ldo_flags_type   nxt_irq_set;

	assign pg_lost     = status_ff.pg & ~cond_sync_ff.pg;
	assign pg_gained   = cond_sync_ff.pg & ~status_ff.pg;
	assign cl_hit      = cond_sync_ff.curlimit & ~status_ff.curlimit;
	assign lost_mask   = {mask_ff[`BIT_REG1_PG_LOST_MASK], mask_ff[`BIT_REG0_PG_LOST_MASK]};
	assign gained_mask = {mask_ff[`BIT_REG1_PG_GAINED_MASK], mask_ff[`BIT_REG0_PG_GAINED_MASK]};
	assign cl_mask     = {mask_ff[`BIT_REG1_CURLIMIT_MASK], mask_ff[`BIT_REG0_CURLIMIT_MASK]};
	// Loss and gain share one power-good interrupt per regulator
	assign nxt_irq_set.pg       = (pg_lost & ~lost_mask) | (pg_gained & ~gained_mask);
	assign nxt_irq_set.curlimit = cl_hit & ~cl_mask;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mask_ff   <= `RST_REGULATOR_IRQ_MASK;
			select_ff <= `RST_LOAD_MEASURE_SELECT;
		end else begin
			if (wr_mask)
				mask_ff <= reg_req.wdata & `MASK_WRITABLE_BITS;
			if (wr_select)
				select_ff <= reg_req.wdata;
		end
	end

	// Read data only changes on a read, so a read never disturbs state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata_ff  <= 8'h00;
			reg_rvalid_ff <= 1'b0;
		end else begin
			reg_rvalid_ff <= reg_req.rd;
			if (reg_req.rd)
				reg_rdata_ff <= rd_mux;
		end
	end

	// ----------------------------------------
	// Condition synchronisers and interrupt events
	// ----------------------------------------
	// Status is a third stage, fed past the masks, so masking never hides it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cond_meta_ff <= '0;
			cond_sync_ff <= '0;
			status_ff    <= '0;
			irq_set_ff   <= '0;
		end else begin
			cond_meta_ff <= ldo_cond;
			cond_sync_ff <= cond_meta_ff;
			status_ff    <= cond_sync_ff;
			irq_set_ff   <= nxt_irq_set;
		end
	end

	// ----------------------------------------
	// Load current measurement
	// ----------------------------------------
	// A write mid-measurement simply restarts; the old run is abandoned
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meas_start_ff        <= 1'b0;
			meas_sel_ff          <= 1'b0;
			result_ff            <= `RST_LOAD_CURRENT;
			measure_ready_irq_ff <= 1'b0;
		end else begin
			meas_start_ff        <= wr_select;
			if (wr_select)
				meas_sel_ff <= reg_req.wdata[`BIT_MEASURE_SELECT];
			if (meas_done)
				result_ff <= meas_result;
			measure_ready_irq_ff <= meas_done & ~measure_ready_mask;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reg1_pg_lost: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(cond_sync_ff.pg[1]) |=> (irq_set_ff.pg[1] == !$past(mask_ff[`BIT_REG1_PG_LOST_MASK])))
		else $error("regulator one loss interrupt wrong");

	a_reg1_pg_gain: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(cond_sync_ff.pg[1]) |=> (irq_set_ff.pg[1] == !$past(mask_ff[`BIT_REG1_PG_GAINED_MASK])))
		else $error("regulator one gain interrupt wrong");

	a_reg1_cl_irq: assert property (@(posedge clk_sys) disable iff (rst)
		irq_set_ff.curlimit[1] |-> $past(cl_hit[1]) && !$past(mask_ff[`BIT_REG1_CURLIMIT_MASK]))
		else $error("regulator one current limit interrupt wrong");

	a_reg0_pg_lost: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(cond_sync_ff.pg[0]) |=> (irq_set_ff.pg[0] == !$past(mask_ff[`BIT_REG0_PG_LOST_MASK])))
		else $error("regulator zero loss interrupt wrong");

	a_reg0_pg_gain: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(cond_sync_ff.pg[0]) |=> (irq_set_ff.pg[0] == !$past(mask_ff[`BIT_REG0_PG_GAINED_MASK])))
		else $error("regulator zero gain interrupt wrong");

	a_reg0_cl_irq: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(cond_sync_ff.curlimit[0]) && !mask_ff[`BIT_REG0_CURLIMIT_MASK] |=> irq_set_ff.curlimit[0])
		else $error("regulator zero current limit interrupt missing");

	a_status_track: assert property (@(posedge clk_sys) disable iff (rst)
		##3 (status_ff == $past(ldo_cond, 3)))
		else $error("status does not track condition");

	a_select_start: assert property (@(posedge clk_sys) disable iff (rst)
		wr_select |=> meas_start_ff && (meas_sel_ff == $past(reg_req.wdata[0])))
		else $error("measurement not started on select write");

	a_start_cause: assert property (@(posedge clk_sys) disable iff (rst)
		meas_start_ff |-> $past(wr_select))
		else $error("spurious measurement start");

	a_high_read: assert property (@(posedge clk_sys) disable iff (rst)
		reg_req.rd && hit_high |=> reg_rdata_ff == {7'h00, $past(result_ff[8])})
		else $error("high result read wrong");

	a_mask_resvd: assert property (@(posedge clk_sys) disable iff (rst)
		(mask_ff[5] == 1'b0) && (mask_ff[1] == 1'b0))
		else $error("reserved mask bits set");

	a_ready_irq: assert property (@(posedge clk_sys) disable iff (rst)
		meas_done |=> (measure_ready_irq_ff == !$past(measure_ready_mask)))
		else $error("ready interrupt wrong");

	a_result_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!meas_done |=> $stable(result_ff))
		else $error("result changed without completion");

	// ----------------------------------------
	// Read path, masking and measurement checks
	// ----------------------------------------
	a_low_read: assert property (@(posedge clk_sys) disable iff (rst)
		reg_req.rd && hit_low |=> reg_rdata_ff == $past(result_ff[7:0]))
		else $error("low result read wrong");

	a_high_resvd: assert property (@(posedge clk_sys) disable iff (rst)
		reg_req.rd && hit_high |=> reg_rdata_ff[7:1] == 7'h00)
		else $error("high result reserved bits set");

	a_mask_rd_resvd: assert property (@(posedge clk_sys) disable iff (rst)
		reg_req.rd && hit_mask |=> (reg_rdata_ff[5] == 1'b0) && (reg_rdata_ff[1] == 1'b0))
		else $error("reserved mask bits read set");

	a_select_read: assert property (@(posedge clk_sys) disable iff (rst)
		reg_req.rd && hit_select |=> reg_rdata_ff[0] == $past(meas_sel_ff))
		else $error("select read disagrees with converter choice");

	a_select_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_select |=> select_ff == $past(reg_req.wdata))
		else $error("select write not stored");

	a_sel_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!wr_select |=> $stable(meas_sel_ff))
		else $error("converter choice changed without write");

	a_unmapped_read: assert property (@(posedge clk_sys) disable iff (rst)
		reg_req.rd && !hit_mask && !hit_select && !hit_high && !hit_low |=> reg_rdata_ff == 8'h00)
		else $error("unmapped read not zero");

	a_rvalid_set: assert property (@(posedge clk_sys) disable iff (rst)
		reg_req.rd |=> reg_rvalid_ff)
		else $error("read not answered");

	a_rvalid_clear: assert property (@(posedge clk_sys) disable iff (rst)
		!reg_req.rd |=> !reg_rvalid_ff)
		else $error("read valid without read");

	a_rdata_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!reg_req.rd |=> $stable(reg_rdata_ff))
		else $error("read data changed without read");

	a_read_no_effect: assert property (@(posedge clk_sys) disable iff (rst)
		reg_req.rd && !reg_req.wr |=> $stable(mask_ff) && $stable(select_ff))
		else $error("read disturbed register state");

	a_mask_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_mask |=> (mask_ff & `MASK_WRITABLE_BITS) == ($past(reg_req.wdata) & `MASK_WRITABLE_BITS))
		else $error("mask write not stored");

	a_reg1_cl_masked: assert property (@(posedge clk_sys) disable iff (rst)
		cl_hit[1] && mask_ff[`BIT_REG1_CURLIMIT_MASK] |=> !irq_set_ff.curlimit[1])
		else $error("masked regulator one current limit raised");

	a_reg0_cl_masked: assert property (@(posedge clk_sys) disable iff (rst)
		cl_hit[0] && mask_ff[`BIT_REG0_CURLIMIT_MASK] |=> !irq_set_ff.curlimit[0])
		else $error("masked regulator zero current limit raised");

	a_reg1_cl_fall: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(cond_sync_ff.curlimit[1]) |=> !irq_set_ff.curlimit[1])
		else $error("regulator one current limit raised on release");

	a_reg0_cl_fall: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(cond_sync_ff.curlimit[0]) |=> !irq_set_ff.curlimit[0])
		else $error("regulator zero current limit raised on release");

	a_reg0_cl_cause: assert property (@(posedge clk_sys) disable iff (rst)
		!cl_hit[0] |=> !irq_set_ff.curlimit[0])
		else $error("regulator zero current limit without event");

	a_reg1_pg_cause: assert property (@(posedge clk_sys) disable iff (rst)
		irq_set_ff.pg[1] |-> $past(pg_lost[1]) || $past(pg_gained[1]))
		else $error("regulator one power-good interrupt without event");

	a_reg0_pg_cause: assert property (@(posedge clk_sys) disable iff (rst)
		irq_set_ff.pg[0] |-> $past(pg_lost[0]) || $past(pg_gained[0]))
		else $error("regulator zero power-good interrupt without event");

	a_result_load: assert property (@(posedge clk_sys) disable iff (rst)
		meas_done |=> result_ff == $past(meas_result))
		else $error("result not captured on completion");

	a_ready_cause: assert property (@(posedge clk_sys) disable iff (rst)
		measure_ready_irq_ff |-> $past(meas_done))
		else $error("ready interrupt without completion");

	a_ready_masked: assert property (@(posedge clk_sys) disable iff (rst)
		meas_done && measure_ready_mask |=> !measure_ready_irq_ff)
		else $error("masked ready interrupt raised");

endmodule
`default_nettype wire

// ### regulator_irq_mask_meter_defines.svh
// Offsets, field positions, reset values and scale constants for the mask and load meter slice
`ifndef REGULATOR_IRQ_MASK_METER_DEFINES_SVH
`define REGULATOR_IRQ_MASK_METER_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_REGULATOR_IRQ_MASK   8'h23
`define OFS_LOAD_MEASURE_SELECT  8'h24
`define OFS_LOAD_CURRENT_HIGH    8'h25
`define OFS_LOAD_CURRENT_LOW     8'h26

// ----------------------------------------
// Mask register fields
// ----------------------------------------
`define BIT_REG1_PG_LOST_MASK    7
`define BIT_REG1_PG_GAINED_MASK  6
`define BIT_REG1_CURLIMIT_MASK   4
`define BIT_REG0_PG_LOST_MASK    3
`define BIT_REG0_PG_GAINED_MASK  2
`define BIT_REG0_CURLIMIT_MASK   0
`define MASK_WRITABLE_BITS       8'hDD
`define RST_REGULATOR_IRQ_MASK   8'hDD

// ----------------------------------------
// Measurement fields
// ----------------------------------------
`define BIT_MEASURE_SELECT       0
`define RST_LOAD_MEASURE_SELECT  8'h00
`define RST_LOAD_CURRENT         9'h000
`define LOAD_RESULT_WIDTH        9
`define LOAD_LSB_MILLIAMP        20
`define LOAD_FULL_SCALE_MILLIAMP 10220

`endif

// ### regulator_irq_mask_meter_pkg.sv
// Types shared by the mask and load meter slice
package regulator_irq_mask_meter_pkg;

	// ----------------------------------------
	// Register port request
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	// ----------------------------------------
	// Per-regulator flags, bit 1 is regulator one
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] pg;
		logic [1:0] curlimit;
	} ldo_flags_type;

endpackage

// ### load_meter_model.sv
// Behavioural load current meter that answers start pulses
`timescale 1ns/100ps
`default_nettype none
module load_meter_model #(
	parameter int DLY = 8
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       start,
	input  wire logic       sel,
	output var  logic       done,
	output var  logic [8:0] result
);
	// Codes differ per converter in every bit
	localparam logic [8:0] RES0 = 9'h0A5;
	localparam logic [8:0] RES1 = 9'h15A;
	int cnt = 0;
	// Result toggles outside the done cycle, so a late sample shows
	always @(posedge clk_sys) begin
		if (rst) begin
			cnt <= 0;
			done <= 1'b0;
			result <= 9'h000;
		end else if (start) begin
			cnt <= DLY;
			done <= 1'b0;
			result <= ~result;
		end else if (cnt == 1) begin
			cnt <= 0;
			done <= 1'b1;
			result <= sel ? RES1 : RES0;
		end else begin
			cnt <= (cnt != 0) ? cnt - 1 : 0;
			done <= 1'b0;
			result <= ~result;
		end
	end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the mask and load meter slice
`timescale 1ns/100ps
`default_nettype none
`include "regulator_irq_mask_meter_defines.svh"
module tb_top;
	import regulator_irq_mask_meter_pkg::*;
	logic clk_sys, rst, rvalid, start, sel, done, rdy_mask, rdy_irq;
	reg_req_type req;
	ldo_flags_type cond, status, irqset;
	logic [7:0] rdata;
	logic [8:0] result;
	logic [3:0] irq_seen;
	int fail_count, num_checks, rdy_seen;

	ldo_irq_mask_and_load_meter u_ldo_irq_mask_and_load_meter (.clk_sys(clk_sys), .rst(rst), .reg_req(req),
		.reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid), .ldo_cond(cond), .status_ff(status), .irq_set_ff(irqset),
		.meas_start_ff(start), .meas_sel_ff(sel), .meas_done(done), .meas_result(result),
		.measure_ready_mask(rdy_mask), .measure_ready_irq_ff(rdy_irq));
	load_meter_model u_load_meter_model (.clk_sys(clk_sys), .rst(rst), .start(start), .sel(sel),
		.done(done), .result(result));

	always #2 clk_sys = ~clk_sys;

	// ----------------------------------------
	// Access and compare tasks
	// ----------------------------------------
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk_val(input logic [8:0] got, input logic [8:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task chk_flags(input logic [3:0] got, input logic [3:0] exp, input string what);
		chk_val({5'h00, got}, {5'h00, exp}, what);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1 req = '{1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		#1 req = '0;
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		#1 req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys);
		#1 req = '0;
		chk_val({8'h00, rvalid}, 9'h001, "rvalid");
		chk_val({1'b0, rdata}, {1'b0, exp}, "rdata");
	endtask
	// Condition edge under a given mask, then wait out the sync latency
	task ev(input logic [7:0] m, input logic [3:0] c, input logic [3:0] exp);
		wr(`OFS_REGULATOR_IRQ_MASK, m);
		cond = c;
		irq_seen = '0;
		repeat (6) begin
			@(posedge clk_sys);
			#1;
			irq_seen = irq_seen | irqset;
		end
		chk_flags(irq_seen, exp, "irq set");
		chk_flags(status, c, "status");
	endtask
	task meas(input logic [7:0] s, input logic m, input logic [8:0] exp);
		int i;
		rdy_mask = m;
		rdy_seen = 0;
		wr(`OFS_LOAD_MEASURE_SELECT, s);
		chk_val({8'h00, start}, 9'h001, "start");
		chk_val({8'h00, sel}, {8'h00, s[0]}, "sel");
		for (i = 0; i < 50 && done !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (i == 50) begin
			fail_count++;
			test_done;
		end
		repeat (3) begin
			@(posedge clk_sys);
			#1;
			if (rdy_irq === 1'b1)
				rdy_seen++;
		end
		chk_val(rdy_seen[8:0], {8'h00, ~m}, "ready irq");
		rd_chk(`OFS_LOAD_CURRENT_HIGH, {7'h00, exp[8]});
		rd_chk(`OFS_LOAD_CURRENT_LOW, exp[7:0]);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		req = '0;
		cond = '0;
		rdy_mask = 1'b1;
		irq_seen = '0;
		rdy_seen = 0;
		fail_count = 0;
		num_checks = 0;
		repeat (12) @(posedge clk_sys);
		#1 rst = 1'b0;
		rd_chk(`OFS_REGULATOR_IRQ_MASK, 8'hDD);
		rd_chk(`OFS_LOAD_MEASURE_SELECT, 8'h00);
		rd_chk(`OFS_LOAD_CURRENT_HIGH, 8'h00);
		rd_chk(`OFS_LOAD_CURRENT_LOW, 8'h00);
		rd_chk(8'h40, 8'h00);
		wr(`OFS_REGULATOR_IRQ_MASK, 8'hFF);
		rd_chk(`OFS_REGULATOR_IRQ_MASK, 8'hDD);
		$display("test reset and access done");
		ev(8'hD9, 4'h4, 4'h4);
		ev(8'hD5, 4'h0, 4'h4);
		ev(8'hD5, 4'h4, 4'h0);
		ev(8'h9D, 4'hC, 4'h8);
		ev(8'h5D, 4'h4, 4'h8);
		ev(8'hCD, 4'h6, 4'h2);
		ev(8'hDC, 4'h7, 4'h1);
		ev(8'hDD, 4'hF, 4'h0);
		ev(8'h00, 4'h0, 4'hC);
		ev(8'hDD, 4'hE, 4'h0);
		ev(8'hDD, 4'h1, 4'h0);
		$display("test masks done");
		meas(8'h01, 1'b0, 9'h15A);
		meas(8'h00, 1'b1, 9'h0A5);
		meas(8'hFE, 1'b0, 9'h0A5);
		rd_chk(`OFS_LOAD_MEASURE_SELECT, 8'hFE);
		wr(`OFS_LOAD_CURRENT_HIGH, 8'hFF);
		rd_chk(`OFS_LOAD_CURRENT_HIGH, 8'h00);
		rd_chk(`OFS_LOAD_CURRENT_LOW, 8'hA5);
		$display("test measurement done");
		test_done;
	end
endmodule
`default_nettype wire
